// [logic/spl_port.sv]
`default_nettype none
module spl_port #(
  parameter bit SOFT_RECOVER = 1'b1
) (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       soft_reset_bit_in,
  // apb slave
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [spl_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [spl_pkg::DATA_W-1:0] pwdata_in,
  input  wire logic [3:0]                 pstrb_in,
  output logic      [spl_pkg::DATA_W-1:0] prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  // receive frames from the link layer
  input  wire spl_pkg::spl_rx_frame_s     rx_frame_in,
  output logic                            rx_ready_out,
  // transmit frames to the link layer
  output spl_pkg::spl_tx_frame_s          tx_frame_out,
  input  wire logic                       tx_ready_in,
  output logic                            comreset_out,
  // interrupt
  output logic                            irq_out
);
  // register bus request and read path
  spl_pkg::spl_reg_req_s      req;
  logic [spl_pkg::DATA_W-1:0] rdata;
  logic                       hit;
  logic [spl_pkg::INT_W-1:0]  int_status, int_mask, int_event, int_clr;

  // link, lock and task file state
  spl_pkg::spl_lock_e lock_d, lock_q;
  logic [7:0]         tfd_d, tfd_q;
  // command list and transmit state
  spl_pkg::spl_tx_e   tx_d, tx_q;
  spl_pkg::spl_slot_s slot_d [spl_pkg::SLOTS];
  spl_pkg::spl_slot_s slot_q [spl_pkg::SLOTS];
  logic [spl_pkg::SLOTS-1:0] issue_d, issue_q;
  logic               soft_reset_bit_seen_d, soft_reset_bit_seen_q;
  logic [3:0]         det_d, det_q;

  // events and cross-group strobes
  logic               rx_take, ev_lock, ev_comreset_done;
  logic               tx_done, ev_soft_reset_bit_done, soft_unlock, clr_busy;
  logic               cur_slot;
  spl_pkg::spl_slot_s cur;

  // one write strobe per register, gated by its own offset
  function automatic logic wr_sel(input spl_pkg::spl_reg_req_s r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // a locked port still lets frames that carry the reset header through
  function automatic logic slot_allowed(input spl_pkg::spl_lock_e lk, input spl_pkg::spl_slot_s s);
    return (lk == spl_pkg::LK_RUN) || ((lk == spl_pkg::LK_LOCKED) && s.hdr_reset);
  endfunction

  spl_apb_slave u_apb (
    .clk_in      (clk_in),
    .soft_reset_bit_in     (soft_reset_bit_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .pstrb_in    (pstrb_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .rdata_in    (rdata),
    .hit_in      (hit),
    .req_out     (req)
  );

  // interrupt status is write-one-to-clear in the low byte
  assign int_clr = wr_sel(req, spl_pkg::OFS_INT_STATUS) && req.strb[0] ?
                   req.wdata[spl_pkg::INT_W-1:0] : '0;

  // every event is a one-cycle pulse into the sticky status
  assign int_event[spl_pkg::INT_REG_FRAME] = rx_take && (rx_frame_in.kind == spl_pkg::FRM_REG_D2H);
  assign int_event[spl_pkg::INT_PIO_SETUP] = rx_take && (rx_frame_in.kind == spl_pkg::FRM_PIO_SETUP);
  assign int_event[spl_pkg::INT_LOCKUP]    = ev_lock;
  assign int_event[spl_pkg::INT_SOFT_RESET_BIT_DONE] = ev_soft_reset_bit_done;
  assign int_event[spl_pkg::INT_COMRESET]  = ev_comreset_done;

  // mask writes use lane 0 only, like the status clear
  spl_irq_ctrl #(
    .W (spl_pkg::INT_W)
  ) u_irq (
    .clk_in     (clk_in),
    .soft_reset_bit_in    (soft_reset_bit_in),
    .event_in   (int_event),
    .clr_in     (int_clr),
    .mask_we_in (wr_sel(req, spl_pkg::OFS_INT_MASK) && req.strb[0]),
    .mask_in    (req.wdata[spl_pkg::INT_W-1:0]),
    .status_out (int_status),
    .mask_out   (int_mask),
    .irq_out    (irq_out)
  );

  // receive is refused while locked or in comreset: this is the hang
  assign rx_ready_out = (lock_q == spl_pkg::LK_RUN);
  assign rx_take      = rx_frame_in.valid && rx_ready_out;
  assign comreset_out = (lock_q == spl_pkg::LK_COMRESET);

  // lock state machine and task file status
  always_comb begin
    lock_d           = lock_q;
    tfd_d            = tfd_q;
    ev_lock          = 1'b0;
    ev_comreset_done = 1'b0;
    case (lock_q)
      spl_pkg::LK_RUN: begin
        // the locking frame's own status never reaches the task file
        if (rx_take && rx_frame_in.kind == spl_pkg::FRM_PIO_SETUP && rx_frame_in.dir_write &&
            !tfd_q[spl_pkg::TFD_BUSY_BIT] &&
            !tfd_q[spl_pkg::TFD_DRQ_BIT]) begin
          lock_d  = spl_pkg::LK_LOCKED;
          ev_lock = 1'b1;
        end else if (rx_take && rx_frame_in.kind != spl_pkg::FRM_OTHER) begin
          tfd_d = rx_frame_in.status;
        end
      end
      spl_pkg::LK_LOCKED: begin
        // no way out but the two resets
        if (soft_unlock) begin
          lock_d = spl_pkg::LK_RUN;
        end
      end
      spl_pkg::LK_COMRESET: begin
        // link renegotiates once the field drops back
        if (det_q != spl_pkg::DET_COMRESET) begin
          lock_d           = spl_pkg::LK_RUN;
          ev_comreset_done = 1'b1;
        end
      end
      default: begin
        lock_d = spl_pkg::LK_RUN;
      end
    endcase
    // a clear-busy header drops bit 7 as its frame goes out
    if (clr_busy) begin
      tfd_d[spl_pkg::TFD_BUSY_BIT] = 1'b0;
    end
    // field value one forces comreset from any state
    if (det_q == spl_pkg::DET_COMRESET) begin
      lock_d = spl_pkg::LK_COMRESET;
      if (lock_q != spl_pkg::LK_COMRESET) begin
        tfd_d = spl_pkg::TFD_RESET;
      end
    end
  end

  // busy set out of reset, so no write setup locks before status arrives
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      lock_q <= spl_pkg::LK_RUN;
      tfd_q  <= spl_pkg::TFD_RESET;
    end else begin
      lock_q <= lock_d;
      tfd_q  <= tfd_d;
    end
  end

  // the slot on the wire follows the transmit state
  assign cur_slot = (tx_q == spl_pkg::TX_SLOT1);
  assign cur      = slot_q[cur_slot];
  assign tx_done  = (tx_q != spl_pkg::TX_IDLE) && tx_ready_in;

  // frame fields come from slot flops and hold until accepted
  assign tx_frame_out.valid      = (tx_q != spl_pkg::TX_IDLE);
  assign tx_frame_out.soft_reset_bit       = cur.soft_reset_bit;
  assign tx_frame_out.cmd_update = cur.cmd_update;

  // transmit engine; slot 0 goes first so the reset pair keeps its order
  always_comb begin
    tx_d         = tx_q;
    soft_reset_bit_seen_d  = soft_reset_bit_seen_q;
    clr_busy     = 1'b0;
    ev_soft_reset_bit_done = 1'b0;
    soft_unlock  = 1'b0;
    case (tx_q)
      spl_pkg::TX_IDLE: begin
        // a locked port only lets reset-header slots go
        if (issue_q[0] && slot_allowed(lock_q, slot_q[0])) begin
          tx_d = spl_pkg::TX_SLOT0;
        end else if (issue_q[1] && slot_allowed(lock_q, slot_q[1])) begin
          tx_d = spl_pkg::TX_SLOT1;
        end
      end
      spl_pkg::TX_SLOT0, spl_pkg::TX_SLOT1: begin
        if (tx_ready_in) begin
          tx_d     = spl_pkg::TX_IDLE;
          clr_busy = cur.hdr_clr_busy;
          // first frame asserts soft reset, second releases it
          if (cur.hdr_reset && cur.soft_reset_bit) begin
            soft_reset_bit_seen_d = 1'b1;
          end else if (cur.hdr_reset && soft_reset_bit_seen_q) begin
            soft_reset_bit_seen_d  = 1'b0;
            ev_soft_reset_bit_done = 1'b1;
            soft_unlock  = SOFT_RECOVER;
          end else begin
            soft_reset_bit_seen_d = 1'b0;
          end
        end
      end
      default: begin
        tx_d = spl_pkg::TX_IDLE;
      end
    endcase
    // comreset aborts any frame in flight
    if (lock_q == spl_pkg::LK_COMRESET) begin
      tx_d        = spl_pkg::TX_IDLE;
      soft_reset_bit_seen_d = 1'b0;
    end
  end

  // transmit state registers
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      tx_q        <= spl_pkg::TX_IDLE;
      soft_reset_bit_seen_q <= 1'b0;
    end else begin
      tx_q        <= tx_d;
      soft_reset_bit_seen_q <= soft_reset_bit_seen_d;
    end
  end

  // software registers: control field, command slots, issue bits
  always_comb begin
    logic [spl_pkg::DATA_W-1:0] ctl;
    ctl     = spl_pkg::apply_strb({28'h0, det_q}, req.wdata, req.strb);
    det_d   = wr_sel(req, spl_pkg::OFS_SATA_CTRL) ? ctl[spl_pkg::DET_W-1:0] : det_q;
    issue_d = issue_q;
    for (int i = 0; i < spl_pkg::SLOTS; i++) begin
      slot_d[i] = slot_q[i];
    end
    // a slot still waiting to go out ignores writes
    if (wr_sel(req, spl_pkg::OFS_CMD_SLOT0) && req.strb[0] && !issue_q[0]) begin
      slot_d[0] = req.wdata[spl_pkg::SLOT_W-1:0];
    end
    if (wr_sel(req, spl_pkg::OFS_CMD_SLOT1) && req.strb[0] && !issue_q[1]) begin
      slot_d[1] = req.wdata[spl_pkg::SLOT_W-1:0];
    end
    if (tx_done) begin
      issue_d[cur_slot] = 1'b0;
    end
    // emptying the list comes before any new issue in the same write
    if (wr_sel(req, spl_pkg::OFS_CMD_ISSUE) && req.strb[0]) begin
      if (req.wdata[spl_pkg::ISSUE_CLR_BIT]) begin
        issue_d = '0;
      end
      issue_d = issue_d | req.wdata[spl_pkg::SLOTS-1:0];
    end
    // a link reset drops the queue; software must rebuild the list
    if (lock_q == spl_pkg::LK_COMRESET) begin
      issue_d = '0;
    end
  end

  // software register flops; the control field comes up released
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      det_q   <= spl_pkg::DET_RESET;
      issue_q <= '0;
      for (int i = 0; i < spl_pkg::SLOTS; i++) begin
        slot_q[i] <= '0;
      end
    end else begin
      det_q   <= det_d;
      issue_q <= issue_d;
      for (int i = 0; i < spl_pkg::SLOTS; i++) begin
        slot_q[i] <= slot_d[i];
      end
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    rdata = '0;
    hit   = 1'b1;
    // the bus slave catches this in the setup cycle
    case (req.addr)
      spl_pkg::OFS_INT_STATUS: rdata = 32'(int_status);
      spl_pkg::OFS_INT_MASK:   rdata = 32'(int_mask);
      spl_pkg::OFS_TASK_FILE:  rdata = 32'(tfd_q);
      spl_pkg::OFS_SATA_CTRL:  rdata = 32'(det_q);
      spl_pkg::OFS_CMD_SLOT0:  rdata = 32'(slot_q[0]);
      spl_pkg::OFS_CMD_SLOT1:  rdata = 32'(slot_q[1]);
      spl_pkg::OFS_CMD_ISSUE:  rdata = 32'(issue_q);
      spl_pkg::OFS_PORT_STATE: begin
        rdata[spl_pkg::ST_LOCKED]   = (lock_q == spl_pkg::LK_LOCKED);
        rdata[spl_pkg::ST_COMRESET] = (lock_q == spl_pkg::LK_COMRESET);
        rdata[spl_pkg::ST_TX_BUSY]  = (tx_q != spl_pkg::TX_IDLE);
      end
      default: hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [logic/spl_pkg.sv]
`default_nettype none
package spl_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_INT_STATUS = 8'h00;
  localparam logic [7:0] OFS_INT_MASK   = 8'h04;
  localparam logic [7:0] OFS_TASK_FILE  = 8'h08;
  localparam logic [7:0] OFS_SATA_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_CMD_SLOT0  = 8'h10;
  localparam logic [7:0] OFS_CMD_SLOT1  = 8'h14;
  localparam logic [7:0] OFS_CMD_ISSUE  = 8'h18;
  localparam logic [7:0] OFS_PORT_STATE = 8'h1c;
  // interrupt status bit positions
  localparam int unsigned INT_REG_FRAME = 0;
  localparam int unsigned INT_PIO_SETUP = 1;
  localparam int unsigned INT_LOCKUP    = 2;
  localparam int unsigned INT_SOFT_RESET_BIT_DONE = 3;
  localparam int unsigned INT_COMRESET  = 4;
  localparam int unsigned INT_W         = 5;
  // task file status byte
  localparam int unsigned TFD_BUSY_BIT = 7;
  localparam int unsigned TFD_DRQ_BIT  = 3;
  localparam logic [7:0]  TFD_RESET    = 8'h80;
  // link control field
  localparam int unsigned DET_W        = 4;
  localparam logic [3:0]  DET_COMRESET = 4'h1;
  localparam logic [3:0]  DET_RESET    = 4'h0;
  // command issue register
  localparam int unsigned SLOTS         = 2;
  localparam int unsigned ISSUE_CLR_BIT = 2;
  localparam int unsigned SLOT_W        = 4;
  // port state bit positions
  localparam int unsigned ST_LOCKED   = 0;
  localparam int unsigned ST_COMRESET = 1;
  localparam int unsigned ST_TX_BUSY  = 2;

  typedef enum logic [1:0] {
    FRM_REG_D2H   = 2'h0,
    FRM_PIO_SETUP = 2'h1,
    FRM_OTHER     = 2'h2
  } spl_frame_e;

  typedef enum logic [1:0] {
    LK_RUN      = 2'b00,
    LK_LOCKED   = 2'b01,
    LK_COMRESET = 2'b11
  } spl_lock_e;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SLOT0 = 2'b01,
    TX_SLOT1 = 2'b11
  } spl_tx_e;

  // one queued register frame plus its header bits; soft_reset_bit lands in bit 0
  typedef struct packed {
    logic hdr_reset;
    logic hdr_clr_busy;
    logic cmd_update;
    logic soft_reset_bit;
  } spl_slot_s;

  typedef struct packed {
    logic       valid;
    spl_frame_e kind;
    logic       dir_write;
    logic [7:0] status;
  } spl_rx_frame_s;

  typedef struct packed {
    logic valid;
    logic soft_reset_bit;
    logic cmd_update;
  } spl_tx_frame_s;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        strb;
  } spl_reg_req_s;

  // merge write data into an old value under byte enables
  function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] wdata,
                                                   input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction
endpackage
`default_nettype wire

// [logic/spl_apb_slave.sv]
`default_nettype none
module spl_apb_slave (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       soft_reset_bit_in,
  // apb side
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [spl_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [spl_pkg::DATA_W-1:0] pwdata_in,
  input  wire logic [3:0]                 pstrb_in,
  output logic      [spl_pkg::DATA_W-1:0] prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  // register file side
  input  wire logic [spl_pkg::DATA_W-1:0] rdata_in,
  input  wire logic                       hit_in,
  output spl_pkg::spl_reg_req_s           req_out
);
  logic [spl_pkg::DATA_W-1:0] prdata_d, prdata_q;
  logic                       hit_d, hit_q;
  logic                       setup;

  // read data and decode are caught in setup, so access needs no wait
  assign setup = psel_in & ~penable_in;

  always_comb begin
    prdata_d = setup ? rdata_in : prdata_q;
    hit_d    = setup ? hit_in : hit_q;
  end

  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      prdata_q <= '0;
      hit_q    <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      hit_q    <= hit_d;
    end
  end

  // unmapped addresses answer with an error and write nothing
  assign pready_out    = 1'b1;
  assign pslverr_out   = psel_in & penable_in & ~hit_q;
  assign prdata_out    = prdata_q;
  assign req_out.wr    = psel_in & penable_in & pwrite_in & hit_q;
  assign req_out.addr  = paddr_in;
  assign req_out.wdata = pwdata_in;
  assign req_out.strb  = pstrb_in;
endmodule
`default_nettype wire

// [logic/spl_irq_ctrl.sv]
`default_nettype none
module spl_irq_ctrl #(
  parameter int unsigned W = 5
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         soft_reset_bit_in,
  // events and software access
  input  wire logic [W-1:0] event_in,
  input  wire logic [W-1:0] clr_in,
  input  wire logic         mask_we_in,
  input  wire logic [W-1:0] mask_in,
  // state
  output logic      [W-1:0] status_out,
  output logic      [W-1:0] mask_out,
  output logic              irq_out
);
  logic [W-1:0] status_d, status_q;
  logic [W-1:0] mask_d, mask_q;

  // a new event beats a clear landing in the same cycle
  always_comb begin
    status_d = (status_q & ~clr_in) | event_in;
    mask_d   = mask_we_in ? mask_in : mask_q;
  end

  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      status_q <= '0;
      mask_q   <= '0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  assign status_out = status_q;
  assign mask_out   = mask_q;
  assign irq_out    = |(status_q & mask_q);
endmodule
`default_nettype wire

// [dv/spl_port_assertions.sv]
`default_nettype none
module spl_port_assertions (
  input wire logic                   clk_in,
  input wire logic                   soft_reset_bit_in,
  input wire logic                   psel_in,
  input wire logic                   penable_in,
  input wire logic                   pready_out,
  input wire logic                   pslverr_out,
  input wire spl_pkg::spl_rx_frame_s rx_frame_in,
  input wire logic                   rx_ready_out,
  input wire spl_pkg::spl_tx_frame_s tx_frame_out,
  input wire logic                   tx_ready_in,
  input wire logic                   comreset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tfd_q, tfd_d;
  logic       known_q, known_d;
  logic       take;
  assign take = rx_frame_in.valid && rx_ready_out;
  // shadow of the task file, trusted only after a status frame
  always_comb begin
    tfd_d = tfd_q;
    known_d = known_q;
    if (take && rx_frame_in.kind != spl_pkg::FRM_OTHER) begin
      tfd_d = rx_frame_in.status;
      known_d = 1'b1;
    end
    // header bits are not visible here, so a sent frame spoils the shadow
    if (comreset_out || (tx_frame_out.valid && tx_ready_in)) begin
      known_d = 1'b0;
    end
  end
  always_ff @(posedge clk_in) begin
    tfd_q <= soft_reset_bit_in ? spl_pkg::TFD_RESET : tfd_d;
    known_q <= soft_reset_bit_in ? 1'b0 : known_d;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (soft_reset_bit_in);
  sequence s_pio_write;
    take && rx_frame_in.kind == spl_pkg::FRM_PIO_SETUP && rx_frame_in.dir_write;
  endsequence
  sequence s_locked;
    !rx_ready_out && !comreset_out;
  endsequence
  AST_LOCK_ENTRY: assert property (s_pio_write ##0 (known_q && !tfd_q[7] && !tfd_q[3]) |=> s_locked)
    else $error("write setup with busy and drq clear did not lock");
  AST_BUSY_BLOCKS: assert property (s_pio_write ##0 (known_q && tfd_q[7]) |=> rx_ready_out)
    else $error("locked although busy was set");
  AST_DRQ_BLOCKS: assert property (s_pio_write ##0 (known_q && tfd_q[3]) |=> rx_ready_out)
    else $error("locked although drq was set");
  AST_STAYS_LOCKED: assert property (s_locked ##0 !(tx_frame_out.valid && tx_ready_in) |=> !rx_ready_out)
    else $error("port left lock by itself");
  AST_COMRESET_HALTS: assert property (comreset_out |-> !rx_ready_out)
    else $error("frames taken during link reset");
  AST_ERR_IN_ACCESS: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("slave error outside access phase");
  AST_ZERO_WAIT: assert property (psel_in && penable_in |-> pready_out)
    else $error("access phase without ready");
  AST_TX_HELD: assert property (tx_frame_out.valid && !tx_ready_in |=>
                                comreset_out || (tx_frame_out.valid && $stable(tx_frame_out)))
    else $error("frame changed before acceptance");
  AST_TX_GAP: assert property (tx_frame_out.valid && tx_ready_in |=> !tx_frame_out.valid)
    else $error("no idle cycle after accepted frame");
endmodule
bind spl_port spl_port_assertions u_chk (
  .clk_in(clk_in), .soft_reset_bit_in(soft_reset_bit_in), .psel_in(psel_in), .penable_in(penable_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .rx_frame_in(rx_frame_in),
  .rx_ready_out(rx_ready_out), .tx_frame_out(tx_frame_out), .tx_ready_in(tx_ready_in),
  .comreset_out(comreset_out)
);
`default_nettype wire

// [dv/spl_dev_model.sv]
`default_nettype none
module spl_dev_model #(
  parameter int DLY = 3
) (
  // link side of the port
  input  wire logic                   clk_in,
  input  wire logic                   rx_ready_in,
  input  wire spl_pkg::spl_tx_frame_s tx_frame_in,
  output spl_pkg::spl_rx_frame_s      rx_frame_out,
  output logic                        tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] got[$];
  int         cnt = 0;
  initial rx_frame_out = '{1'b0, spl_pkg::FRM_OTHER, 1'b0, 8'h5a};
  // frame held until taken; idle lines then show kind other with write and status inverted
  task automatic send(input spl_pkg::spl_frame_e k, input logic w, input logic [7:0] st);
    @(posedge clk_in);
    rx_frame_out <= '{1'b1, k, w, st};
    do @(posedge clk_in); while (rx_ready_in !== 1'b1);
    rx_frame_out <= '{1'b0, spl_pkg::FRM_OTHER, ~w, ~st};
  endtask
  // slow acceptance proves the port keeps its frame steady
  assign tx_ready_out = tx_frame_in.valid && cnt == DLY;
  always @(posedge clk_in) begin
    if (tx_ready_out) begin
      got.push_back({tx_frame_in.soft_reset_bit, tx_frame_in.cmd_update});
    end
    cnt <= (tx_frame_in.valid && !tx_ready_out) ? cnt + 1 : 0;
  end
endmodule
`default_nettype wire

// [dv/spl_port_tb.sv]
`default_nettype none
module spl_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_in = 1'b0;
  logic                   soft_reset_bit_in = 1'b1;
  logic                   psel = 1'b0;
  logic                   pen = 1'b0;
  logic                   pwr = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata, rd;
  logic                   pready, pslverr, rx_ready, tx_ready, comreset, irq, err_seen;
  spl_pkg::spl_rx_frame_s rx_frame;
  spl_pkg::spl_tx_frame_s tx_frame;
  int                     errors = 0;
  int                     n_compared = 0;
  logic [7:0]             st_tab[2] = '{8'h08, 8'h80};
  always #10 clk_in = ~clk_in;
  spl_port DUT (
    .clk_in(clk_in), .soft_reset_bit_in(soft_reset_bit_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rx_frame_in(rx_frame), .rx_ready_out(rx_ready), .tx_frame_out(tx_frame),
    .tx_ready_in(tx_ready), .comreset_out(comreset), .irq_out(irq)
  );
  spl_dev_model #(.DLY(3)) dev (
    .clk_in(clk_in), .rx_ready_in(rx_ready), .tx_frame_in(tx_frame), .rx_frame_out(rx_frame),
    .tx_ready_out(tx_ready)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; data taken at the very edge where pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // locks the port from a known idle task file
  task automatic lock_port();
    dev.send(spl_pkg::FRM_REG_D2H, 1'b0, 8'h00);
    dev.send(spl_pkg::FRM_PIO_SETUP, 1'b1, 8'h00);
    rdc(spl_pkg::OFS_PORT_STATE, 32'h1);
  endtask
  initial begin
    #200us;
    errors++;
    $display("BAD %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    soft_reset_bit_in <= 1'b0;
    rdc(spl_pkg::OFS_TASK_FILE, 32'h80);
    rdc(spl_pkg::OFS_INT_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err_seen), 32'h1);
    apb(1'b1, spl_pkg::OFS_INT_MASK, 32'h1f);
    rdc(spl_pkg::OFS_INT_MASK, 32'h1f);
    $display("register test done");
    // drq then busy set: write setup must pass without locking
    for (int i = 0; i < 2; i++) begin
      dev.send(spl_pkg::FRM_REG_D2H, 1'b0, st_tab[i]);
      dev.send(spl_pkg::FRM_PIO_SETUP, 1'b1, st_tab[i]);
      rdc(spl_pkg::OFS_PORT_STATE, 32'h0);
      rdc(spl_pkg::OFS_INT_STATUS, 32'h3);
      chk(32'(irq), 32'h1);
      apb(1'b1, spl_pkg::OFS_INT_STATUS, 32'h1f);
    end
    $display("no-lock test done");
    dev.send(spl_pkg::FRM_PIO_SETUP, 1'b0, 8'h00);
    rdc(spl_pkg::OFS_PORT_STATE, 32'h0);
    // an unrelated frame leaves task file and status alone
    dev.send(spl_pkg::FRM_OTHER, 1'b1, 8'h88);
    rdc(spl_pkg::OFS_TASK_FILE, 32'h0);
    rdc(spl_pkg::OFS_INT_STATUS, 32'h2);
    apb(1'b1, spl_pkg::OFS_INT_STATUS, 32'h1f);
    lock_port();
    rdc(spl_pkg::OFS_INT_STATUS, 32'h7);
    chk(32'(rx_ready), 32'h0);
    repeat (50) @(posedge clk_in);
    rdc(spl_pkg::OFS_PORT_STATE, 32'h1);
    apb(1'b1, spl_pkg::OFS_INT_STATUS, 32'h1f);
    @(negedge clk_in);
    chk(32'(irq), 32'h0);
    $display("lockup test done");
    // soft reset pair: empty the list, then two frames
    apb(1'b1, spl_pkg::OFS_CMD_ISSUE, 32'h4);
    apb(1'b1, spl_pkg::OFS_CMD_SLOT0, 32'hd);
    apb(1'b1, spl_pkg::OFS_CMD_SLOT1, 32'h8);
    apb(1'b1, spl_pkg::OFS_CMD_ISSUE, 32'h7);
    for (int i = 0; i < 200 && dev.got.size() < 2; i++) @(posedge clk_in);
    chk(32'(dev.got.size()), 32'h2);
    chk(32'(dev.got[0]), 32'h2);
    chk(32'(dev.got[1]), 32'h0);
    rdc(spl_pkg::OFS_PORT_STATE, 32'h0);
    rdc(spl_pkg::OFS_INT_STATUS, 32'h8);
    rdc(spl_pkg::OFS_CMD_ISSUE, 32'h0);
    apb(1'b1, spl_pkg::OFS_INT_STATUS, 32'h1f);
    $display("soft reset test done");
    // port reset held for a while, then released
    lock_port();
    apb(1'b1, spl_pkg::OFS_SATA_CTRL, 32'(spl_pkg::DET_COMRESET));
    repeat (2) @(negedge clk_in);
    chk(32'(comreset), 32'h1);
    apb(1'b0, spl_pkg::OFS_PORT_STATE, 32'h0);
    chk(32'(rd[1]), 32'h1);
    repeat (20) @(posedge clk_in);
    apb(1'b1, spl_pkg::OFS_SATA_CTRL, 32'(spl_pkg::DET_RESET));
    repeat (2) @(negedge clk_in);
    chk(32'(comreset), 32'h0);
    chk(32'(rx_ready), 32'h1);
    rdc(spl_pkg::OFS_TASK_FILE, 32'h80);
    apb(1'b0, spl_pkg::OFS_INT_STATUS, 32'h0);
    chk(32'(rd[4]), 32'h1);
    $display("port reset test done");
    // a clear-busy header alone drops busy once its frame is accepted
    apb(1'b1, spl_pkg::OFS_CMD_SLOT0, 32'h4);
    apb(1'b1, spl_pkg::OFS_CMD_ISSUE, 32'h1);
    for (int i = 0; i < 200 && dev.got.size() < 3; i++) @(posedge clk_in);
    chk(32'(dev.got.size()), 32'h3);
    rdc(spl_pkg::OFS_TASK_FILE, 32'h0);
    $display("clear busy test done");
    stop_test();
  end
endmodule
`default_nettype wire
